/* rtl/adc_trim_pkg.sv */
// Shared constants and carrier types for the conversion trim stage
package adc_trim_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int RESULT_W  = 16;           // Conversion result width
  localparam int TRIM_W    = 15;           // Trim field width
  localparam int TRIM_MSB  = 14;           // Top bit of a trim field
  localparam int GAIN_FRAC = 14;           // Fraction bits of gain code
  localparam int OFS_FRAC  = 2;            // Quarter-LSB offset steps
  localparam int SUM_W     = 20;           // Signed offset sum width
  localparam int PROD_W    = 36;           // Signed product width
  localparam int ADDR_W    = 16;           // Decoded APB address bits

  // ---------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] GAIN_TRIM_OFF   = 16'h2270;
  localparam logic [ADDR_W-1:0] OFFSET_TRIM_OFF = 16'h22c8;
  localparam logic [ADDR_W-1:0] LAST_RESULT_OFF = 16'h22f0;

  // ---------------------------------------------------------------
  // Reset values and special codes
  // ---------------------------------------------------------------
  localparam logic [TRIM_W-1:0]   GAIN_TRIM_RST   = 15'h4000;
  localparam logic [TRIM_W-1:0]   OFFSET_TRIM_RST = 15'h0000;
  localparam logic [TRIM_W-1:0]   GAIN_UNITY      = 15'h4000;
  localparam logic [TRIM_W-1:0]   GAIN_ILLEGAL    = 15'h0000;
  localparam logic [TRIM_W-1:0]   OFFSET_NONE     = 15'h0000;
  localparam logic [RESULT_W-1:0] RESULT_RST      = 16'h0000;
  localparam logic [RESULT_W-1:0] RESULT_MAX      = 16'hffff;
  localparam logic [RESULT_W-1:0] RESULT_MIN      = 16'h0000;

  // ---------------------------------------------------------------
  // Input amplifier gain setting of a conversion
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    AMP_GAIN_1   = 3'b000,
    AMP_GAIN_1P5 = 3'b001,
    AMP_GAIN_2   = 3'b010,
    AMP_GAIN_4   = 3'b011,
    AMP_GAIN_9   = 3'b100
  } amp_gain_t;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [RESULT_W-1:0] data;        // Raw conversion result
    amp_gain_t           amp_gain;    // Amplifier gain in use
    logic                is_tia;      // From the transimpedance channel
    logic                is_temp;     // From the temperature sensor
  } raw_sample_t;

  typedef struct packed {
    logic                valid;       // One-cycle result strobe
    logic [RESULT_W-1:0] data;        // Corrected conversion result
  } trim_result_t;

endpackage

/* rtl/trim_offset_add.sv */
// Quarter-LSB offset correction adder
`timescale 1ns/1ns
`default_nettype none
module trim_offset_add (
  input  wire logic [adc_trim_pkg::RESULT_W-1:0]     raw,
  input  wire logic [adc_trim_pkg::TRIM_W-1:0]       offset_code,
  input  wire logic                                  apply,
  output logic signed [adc_trim_pkg::SUM_W-1:0]      sum
);

  // ---------------------------------------------------------------
  // Operands in quarter-LSB units
  // ---------------------------------------------------------------
  logic signed [adc_trim_pkg::SUM_W-1:0] raw_q;    // Raw result times four
  logic signed [adc_trim_pkg::SUM_W-1:0] ofs_q;    // Sign-extended offset

  // Two fraction bits appended below the raw result
  assign raw_q = $signed({2'b00, raw, 2'b00});

  // Offset is twos complement, extended from bit 14
  assign ofs_q = apply
    ? $signed({{(adc_trim_pkg::SUM_W - adc_trim_pkg::TRIM_W){offset_code[adc_trim_pkg::TRIM_MSB]}},
               offset_code})
    : '0;

  // Range always fits: no overflow in twenty bits
  assign sum = raw_q + ofs_q;

endmodule
`default_nettype wire

/* rtl/trim_gain_scale.sv */
// Gain multiplier with saturation to the result range
`timescale 1ns/1ns
`default_nettype none
module trim_gain_scale (
  input  wire logic signed [adc_trim_pkg::SUM_W-1:0]  sum,
  input  wire logic [adc_trim_pkg::TRIM_W-1:0]        gain_code,
  output logic [adc_trim_pkg::RESULT_W-1:0]           result
);

  // ---------------------------------------------------------------
  // Product and rescale
  // ---------------------------------------------------------------
  logic signed [adc_trim_pkg::PROD_W-1:0] product;  // Full signed product
  logic signed [adc_trim_pkg::SUM_W-1:0]  scaled;   // Back in LSB units

  // Gain is unsigned 1.14, multiplier is code over 0x4000
  assign product = sum * $signed({1'b0, gain_code});

  // Drop fourteen gain and two offset fraction bits
  assign scaled = product[adc_trim_pkg::PROD_W-1:
                          adc_trim_pkg::GAIN_FRAC + adc_trim_pkg::OFS_FRAC];

  // Saturate; illegal zero code forces zero
  always_comb begin
    if (gain_code == adc_trim_pkg::GAIN_ILLEGAL) begin
      result = adc_trim_pkg::RESULT_MIN;
    end else if (scaled < 0) begin
      result = adc_trim_pkg::RESULT_MIN;
    end else if (scaled[adc_trim_pkg::SUM_W-1:adc_trim_pkg::RESULT_W] != '0) begin
      result = adc_trim_pkg::RESULT_MAX;
    end else begin
      result = scaled[adc_trim_pkg::RESULT_W-1:0];
    end
  end

endmodule
`default_nettype wire

/* rtl/adc_gain_offset_trim.sv */
// Conversion trim stage: APB trim registers and correction datapath
`timescale 1ns/1ns
`default_nettype none

// Operation
// - Gain trim at amp gain 1.5, aux only
// - Gain field bits 14:0, bit 14 integer part
// - Gain code 0x4000 leaves result unscaled
// - Gain code zero gives result zero
// - Gain code 0x2000 halves the result
// - Codes above 0x4000 raise, up to two
// - Codes below 0x4000 lower, down to 0.000061
// - Offset trim applied at amp gain 2
// - Offset field is fifteen-bit twos complement
// - Offset step is a quarter LSB
// - Offset spans -4096 to +4095.75 LSB
// - Offset zero changes nothing, resets zero
module adc_gain_offset_trim (
  input  wire logic                                clk_sys,
  input  wire logic                                rst_n,
  // APB slave
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [31:0]                         paddr,
  input  wire logic [31:0]                         pwdata,
  input  wire logic [3:0]                          pstrb,
  output logic                                     pready,
  output logic [31:0]                              prdata,
  output logic                                     pslverr,
  // Raw conversions from the converter, same clock
  input  wire logic                                sample_valid,
  input  wire adc_trim_pkg::raw_sample_t           sample,
  // Corrected conversions
  output logic                                     result_valid,
  output logic [adc_trim_pkg::RESULT_W-1:0]        conversion_result
);

  // ---------------------------------------------------------------
  // Trim registers
  // ---------------------------------------------------------------
  logic [adc_trim_pkg::TRIM_W-1:0]   gain_trim_ff;     // Gain code 1.14
  logic [adc_trim_pkg::TRIM_W-1:0]   offset_trim_ff;   // Offset code

  // ---------------------------------------------------------------
  // APB response state
  // ---------------------------------------------------------------
  logic                              pready_ff;        // Access answer
  logic [31:0]                       prdata_ff;        // Read data
  logic                              pslverr_ff;       // Unmapped address or readback write
  logic [31:0]                       nxt_prdata;       // Read mux
  logic                              nxt_pslverr;      // Decode miss or readback write

  // ---------------------------------------------------------------
  // Datapath state
  // ---------------------------------------------------------------
  adc_trim_pkg::raw_sample_t         stage_ff;         // Captured sample
  logic                              stage_valid_ff;   // Capture strobe
  logic                              stage_gain_ff;    // Gain trim selected
  logic                              stage_ofs_ff;     // Offset trim selected
  adc_trim_pkg::trim_result_t        out_ff;           // Output register
  logic [adc_trim_pkg::RESULT_W-1:0] last_result_ff;   // Readback copy

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  logic [adc_trim_pkg::ADDR_W-1:0]   addr_lo;          // Decoded bits
  logic                              addr_hi_zero;     // Upper bits clear
  logic                              hit_gain;         // Gain trim address
  logic                              hit_offset;       // Offset trim address
  logic                              hit_result;       // Result readback
  logic                              access_start;     // First access cycle
  logic                              access_done;      // Completing edge
  logic                              wr_gain;          // Gain write commits
  logic                              wr_offset;        // Offset write commits
  logic                              lane_lo;          // Byte lane 0 on
  logic                              lane_hi;          // Byte lane 1 on

  // ---------------------------------------------------------------
  // Correction helpers
  // ---------------------------------------------------------------
  logic                              sel_gain;         // Gain applies now
  logic                              sel_ofs;          // Offset applies now
  logic [adc_trim_pkg::TRIM_W-1:0]   gain_used;        // Gain for this sample
  logic signed [adc_trim_pkg::SUM_W-1:0] ofs_sum;      // Offset stage out
  logic [adc_trim_pkg::RESULT_W-1:0] scaled_result;    // Gain stage out

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  assign addr_lo      = paddr[adc_trim_pkg::ADDR_W-1:0];
  assign addr_hi_zero = (paddr[31:adc_trim_pkg::ADDR_W] == '0);
  assign hit_gain     = addr_hi_zero && (addr_lo == adc_trim_pkg::GAIN_TRIM_OFF);
  assign hit_offset   = addr_hi_zero && (addr_lo == adc_trim_pkg::OFFSET_TRIM_OFF);
  assign hit_result   = addr_hi_zero && (addr_lo == adc_trim_pkg::LAST_RESULT_OFF);

  // Access phase without an answer yet
  assign access_start = psel && penable && !pready_ff;

  // Master samples pready at this edge
  assign access_done  = psel && penable && pready_ff;

  // Fields live in byte lanes 0 and 1
  assign lane_lo      = pstrb[0];
  assign lane_hi      = pstrb[1];

  // Writes commit only at the completing edge
  assign wr_gain      = access_done && pwrite && hit_gain;
  assign wr_offset    = access_done && pwrite && hit_offset;

  // ---------------------------------------------------------------
  // Read mux and error decode
  // ---------------------------------------------------------------
  // Reserved bits read as zero: 31:15 of the trims, 31:16 of the result
  always_comb begin
    nxt_prdata  = 32'h0000_0000;
    nxt_pslverr = 1'b0;
    if (hit_gain) begin
      nxt_prdata[adc_trim_pkg::TRIM_MSB:0] = gain_trim_ff;
    end else if (hit_offset) begin
      nxt_prdata[adc_trim_pkg::TRIM_MSB:0] = offset_trim_ff;
    end else if (hit_result) begin
      nxt_prdata[adc_trim_pkg::RESULT_W-1:0] = last_result_ff;
      // Readback register takes no writes
      nxt_pslverr = pwrite;
    end else begin
      // Unmapped address answers with an error
      nxt_pslverr = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // APB answer: one wait state, then pready for one cycle
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pready_ff <= 1'b0;
    end else if (access_start) begin
      pready_ff <= 1'b1;
    end else begin
      pready_ff <= 1'b0;
    end
  end

  // Read data and error stand while pready is high
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (access_start) begin
      prdata_ff  <= pwrite ? 32'h0000_0000 : nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end else begin
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Gain trim register, reset to unity
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gain_trim_ff <= adc_trim_pkg::GAIN_TRIM_RST;
    end else if (wr_gain) begin
      // Bits 7:0 from lane 0, bits 14:8 from lane 1
      if (lane_lo) begin
        gain_trim_ff[7:0] <= pwdata[7:0];
      end
      if (lane_hi) begin
        gain_trim_ff[adc_trim_pkg::TRIM_MSB:8] <= pwdata[adc_trim_pkg::TRIM_MSB:8];
      end
    end
  end

  // ---------------------------------------------------------------
  // Offset trim register, reset to no correction
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      offset_trim_ff <= adc_trim_pkg::OFFSET_TRIM_RST;
    end else if (wr_offset) begin
      if (lane_lo) begin
        offset_trim_ff[7:0] <= pwdata[7:0];
      end
      if (lane_hi) begin
        offset_trim_ff[adc_trim_pkg::TRIM_MSB:8] <= pwdata[adc_trim_pkg::TRIM_MSB:8];
      end
    end
  end

  // ---------------------------------------------------------------
  // Trim selection per conversion
  // ---------------------------------------------------------------
  // Gain trim skips transimpedance and temperature results
  assign sel_gain = (sample.amp_gain == adc_trim_pkg::AMP_GAIN_1P5)
                    && !sample.is_tia && !sample.is_temp;

  // Offset trim for every conversion at gain two
  assign sel_ofs  = (sample.amp_gain == adc_trim_pkg::AMP_GAIN_2);

  // ---------------------------------------------------------------
  // Capture stage: sample and its trim choice
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stage_valid_ff <= 1'b0;
      stage_gain_ff  <= 1'b0;
      stage_ofs_ff   <= 1'b0;
    end else begin
      stage_valid_ff <= sample_valid;
      stage_gain_ff  <= sample_valid && sel_gain;
      stage_ofs_ff   <= sample_valid && sel_ofs;
    end
  end

  // Sample word held until the next conversion
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stage_ff <= '0;
    end else if (sample_valid) begin
      stage_ff <= sample;
    end
  end

  // ---------------------------------------------------------------
  // Correction datapath
  // ---------------------------------------------------------------
  // Untrimmed conversions pass through at unity gain
  assign gain_used = stage_gain_ff ? gain_trim_ff : adc_trim_pkg::GAIN_UNITY;

  // Offset is added first, in quarter-LSB units
  trim_offset_add u_offset (
    .raw         (stage_ff.data),
    .offset_code (offset_trim_ff),
    .apply       (stage_ofs_ff),
    .sum         (ofs_sum)
  );

  // Then the gain multiplier and the clamp
  trim_gain_scale u_gain (
    .sum       (ofs_sum),
    .gain_code (gain_used),
    .result    (scaled_result)
  );

  // ---------------------------------------------------------------
  // Output register
  // ---------------------------------------------------------------
  // Strobe lasts one cycle; data holds until the next
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      out_ff.valid <= 1'b0;
      out_ff.data  <= adc_trim_pkg::RESULT_RST;
    end else begin
      out_ff.valid <= stage_valid_ff;
      if (stage_valid_ff) begin
        out_ff.data <= scaled_result;
      end
    end
  end

  // Copy of the last result for software readback
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      last_result_ff <= adc_trim_pkg::RESULT_RST;
    end else if (stage_valid_ff) begin
      last_result_ff <= scaled_result;
    end
  end

  // ---------------------------------------------------------------
  // Outputs, each straight from a flip-flop
  // ---------------------------------------------------------------
  assign pready            = pready_ff;
  assign prdata            = prdata_ff;
  assign pslverr           = pslverr_ff;
  assign result_valid      = out_ff.valid;
  assign conversion_result = out_ff.data;

endmodule
`default_nettype wire

/* verif/adc_gain_offset_trim_sva.sv */
// Port assertions for the conversion trim stage
`timescale 1ns/1ns
`default_nettype none
module adc_gain_offset_trim_sva (
  input wire logic                               clk_sys,
  input wire logic                               rst_n,
  input wire logic                               psel,
  input wire logic                               penable,
  input wire logic                               pready,
  input wire logic [31:0]                        prdata,
  input wire logic                               pslverr,
  input wire logic                               sample_valid,
  input wire adc_trim_pkg::raw_sample_t          sample,
  input wire logic                               result_valid,
  input wire logic [adc_trim_pkg::RESULT_W-1:0]  conversion_result
);
  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  logic plain;  // Sample that no trim may touch
  assign plain = sample_valid && (sample.amp_gain != adc_trim_pkg::AMP_GAIN_2) &&
    (sample.amp_gain != adc_trim_pkg::AMP_GAIN_1P5 || sample.is_tia || sample.is_temp);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // -------------------------------------------------------------
  // Register bus
  // -------------------------------------------------------------
  a_access_wait: assert property (psel && penable && !pready |=> pready)
    else $error("access phase not answered after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_ready_cause: assert property (pready |-> $past(psel) && $past(penable))
    else $error("pready without an access phase");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr outside a completion");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero while idle");

  // -------------------------------------------------------------
  // Datapath
  // -------------------------------------------------------------
  a_result_latency: assert property (sample_valid |-> ##2 result_valid)
    else $error("result strobe missing two cycles after sample");
  a_result_cause: assert property (result_valid |-> $past(sample_valid, 2))
    else $error("result strobe without a sample");
  a_result_hold: assert property (!result_valid |-> $stable(conversion_result))
    else $error("result changed without a strobe");
  a_plain_pass: assert property (
    plain |-> ##2 conversion_result == $past(sample.data, 2))
    else $error("untrimmed sample altered");
endmodule
`default_nettype wire

/* verif/adc_gain_offset_trim_test.sv */
// Self-checking bench for the conversion trim stage
`timescale 1ns/1ns
`default_nettype none
module adc_gain_offset_trim_test;
  // -------------------------------------------------------------
  // Constants and stimulus rows
  // -------------------------------------------------------------
  localparam adc_trim_pkg::amp_gain_t G1  = adc_trim_pkg::AMP_GAIN_1;
  localparam adc_trim_pkg::amp_gain_t G15 = adc_trim_pkg::AMP_GAIN_1P5;
  localparam adc_trim_pkg::amp_gain_t G2  = adc_trim_pkg::AMP_GAIN_2;
  localparam logic [31:0] A_GAIN = {16'h0000, adc_trim_pkg::GAIN_TRIM_OFF};
  localparam logic [31:0] A_OFS  = {16'h0000, adc_trim_pkg::OFFSET_TRIM_OFF};
  localparam logic [31:0] A_LAST = {16'h0000, adc_trim_pkg::LAST_RESULT_OFF};
  typedef struct packed {
    logic [15:0]             raw;   // Raw result
    adc_trim_pkg::amp_gain_t amp;   // Amplifier gain
    logic [1:0]              ch;    // {tia, temp}
    logic [14:0]             gain;  // Gain trim
    logic [14:0]             ofs;   // Offset trim
    logic [15:0]             exp;   // Expected result
  } row_t;
  row_t rows [18] = '{
    '{16'h1000, G15, 2'h0, 15'h4000, 15'h0000, 16'h1000},
    '{16'h1000, G15, 2'h0, 15'h0000, 15'h0000, 16'h0000},
    '{16'h1001, G15, 2'h0, 15'h2000, 15'h0000, 16'h0800},
    '{16'h8000, G15, 2'h0, 15'h4001, 15'h0000, 16'h8002},
    '{16'h8000, G15, 2'h0, 15'h3fff, 15'h0000, 16'h7ffe},
    '{16'hffff, G15, 2'h0, 15'h7fff, 15'h0000, 16'hffff},
    '{16'hffff, G15, 2'h0, 15'h0001, 15'h0000, 16'h0003},
    '{16'h1000, G15, 2'h2, 15'h2000, 15'h0000, 16'h1000},
    '{16'h1000, G15, 2'h1, 15'h2000, 15'h0000, 16'h1000},
    '{16'h1000, G1, 2'h0, 15'h2000, 15'h0000, 16'h1000},
    '{16'h1000, G2, 2'h0, 15'h2000, 15'h3fff, 16'h1fff},
    '{16'h0800, G2, 2'h0, 15'h4000, 15'h4000, 16'h0000},
    '{16'h1000, G2, 2'h0, 15'h4000, 15'h7fff, 16'h0fff},
    '{16'h1000, G2, 2'h0, 15'h4000, 15'h0004, 16'h1001},
    '{16'h1000, G15, 2'h0, 15'h4000, 15'h3fff, 16'h1000},
    '{16'hffff, G2, 2'h0, 15'h4000, 15'h3fff, 16'hffff},
    '{16'h1000, adc_trim_pkg::AMP_GAIN_9, 2'h0, 15'h2000, 15'h3fff, 16'h1000},
    '{16'h1000, G2, 2'h0, 15'h4000, 15'h0000, 16'h1000}};

  // -------------------------------------------------------------
  // Signals
  // -------------------------------------------------------------
  logic                      clk_sys = 1'b0;      // Core clock
  logic                      rst_n = 1'b0;        // Async reset
  logic                      psel = 1'b0;         // APB select
  logic                      penable = 1'b0;      // APB access
  logic                      pwrite = 1'b0;       // APB direction
  logic [31:0]               paddr = 32'h0;       // APB address
  logic [31:0]               pwdata = 32'h0;      // APB write data
  logic [3:0]                pstrb = 4'h0;        // APB strobes
  logic                      pready;              // APB done
  logic [31:0]               prdata;              // APB read data
  logic                      pslverr;             // APB error
  logic                      sample_valid = 1'b0; // Raw strobe
  adc_trim_pkg::raw_sample_t sample = '0;         // Raw conversion
  logic                      result_valid;        // Result strobe
  logic [15:0]               conversion_result;   // Corrected result
  int                        mismatches = 0;      // Failed compares
  int                        checked = 0;         // All compares
  logic [31:0]               rd;                  // Last read data
  logic                      err;                 // Last error flag
  logic [15:0]               expq [$];            // Results due, in order

  adc_gain_offset_trim i_adc_gain_offset_trim (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .sample_valid(sample_valid), .sample(sample),
    .result_valid(result_valid), .conversion_result(conversion_result));

  always #2 clk_sys = ~clk_sys;  // 250 MHz

  // -------------------------------------------------------------
  // Tasks
  // -------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer, then one idle cycle
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge clk_sys);
    penable <= 1'b1;
    // Hold the request until pready is sampled high at a rising edge
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) check("pready wait", 32'h0, 32'h1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic expect_read(input string what, input logic [31:0] a,
                             input logic [31:0] exp, input logic e);
    apb(1'b0, a, 32'h0, 4'h0);
    check(what, rd, exp);
    check("pslverr", {31'h0, err}, {31'h0, e});
  endtask

  // One sample; the monitor compares its result
  task automatic send(input row_t r);
    sample       <= '{r.raw, r.amp, r.ch[1], r.ch[0]};
    sample_valid <= 1'b1;
    expq.push_back(r.exp);
    @(posedge clk_sys);
    sample_valid <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic conclude;
    $display("Comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Result monitor, sampled mid-cycle
  always @(negedge clk_sys) begin
    if (result_valid === 1'b1) begin
      if (expq.size() == 0) check("spare result", 32'h1, 32'h0);
      else check("result", {16'h0, conversion_result}, {16'h0, expq.pop_front()});
    end
  end

  // Watchdog
  initial begin
    #40000;
    mismatches++;
    conclude();
  end

  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    expect_read("gain reset", A_GAIN, 32'h00004000, 1'b0);
    expect_read("offset reset", A_OFS, 32'h0, 1'b0);
    expect_read("last reset", A_LAST, 32'h0, 1'b0);
    $display("Test reset values done");
    foreach (rows[i]) begin
      apb(1'b1, A_GAIN, {17'h0, rows[i].gain}, 4'hf);
      apb(1'b1, A_OFS, {17'h0, rows[i].ofs}, 4'hf);
      send(rows[i]);
    end
    expect_read("last result", A_LAST, 32'h00001000, 1'b0);
    $display("Test row table done");
    apb(1'b1, A_GAIN, 32'hffffffff, 4'hf);
    expect_read("gain field", A_GAIN, 32'h00007fff, 1'b0);
    apb(1'b1, A_GAIN, 32'h00002000, 4'h2);
    expect_read("gain lane1", A_GAIN, 32'h000020ff, 1'b0);
    expect_read("unmapped", 32'h00001000, 32'h0, 1'b1);
    expect_read("high bits", 32'h00012270, 32'h0, 1'b1);
    apb(1'b1, A_LAST, 32'h00001234, 4'hf);
    check("ro write", {31'h0, err}, 32'h1);
    $display("Test fields and refusals done");
    apb(1'b1, A_GAIN, 32'h00002000, 4'hf);
    for (int i = 1; i <= 4; i++) begin
      sample       <= '{16'(2 * i), G15, 1'b0, 1'b0};
      sample_valid <= 1'b1;
      expq.push_back(16'(i));
      @(posedge clk_sys);
    end
    sample_valid <= 1'b0;
    repeat (3) @(posedge clk_sys);
    expect_read("stream last", A_LAST, 32'h00000004, 1'b0);
    check("results pending", 32'(expq.size()), 32'h0);
    $display("Test back to back done");
    apb(1'b1, A_OFS, 32'h00000123, 4'hf);
    expect_read("offset set", A_OFS, 32'h00000123, 1'b0);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    expect_read("gain rereset", A_GAIN, 32'h00004000, 1'b0);
    expect_read("offset rereset", A_OFS, 32'h0, 1'b0);
    expect_read("last rereset", A_LAST, 32'h0, 1'b0);
    $display("Test mid-run reset done");
    conclude();
  end
endmodule

bind adc_gain_offset_trim adc_gain_offset_trim_sva i_adc_gain_offset_trim_sva (
  .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .sample_valid(sample_valid), .sample(sample),
  .result_valid(result_valid), .conversion_result(conversion_result));
`default_nettype wire
